// *** design/indexer_defs.vh ***
// constants and register map for the indexer station and jog sequencer
//
// Function
// - target station above division count minus one raises next-station warning
// - start during motion is ignored; host restarts only after done flag
// - after in-position, wait programmable delay then select torque limit 2
// - at power-up, in-position set if already inside a station window
// - direct speed value accepted only with two fieldbus stations occupied
// - indexer operation runs only when operation select leading digit is 1
// - manual mode is select bit1 on and select bit2 off
// - manual mode ignores next-station select and speed-select bits
// - jog type digit: 0 indexer jog, 1 plain jog
// - station direction: 0 stations counted clockwise, 1 counter-clockwise
// - jog uses point-table entry 1 speed and ramps while start held; code steps one count per clock, no ramp
// - indexer jog release positions to first station reachable by stopping
// - plain jog release decelerates to stop anywhere; code stops on the release clock, no deceleration
// - auto mode 2 rising start positions to next-station word at word speed; code moves one count per clock, speed only reported
`ifndef INDEXER_DEFS_VH
`define INDEXER_DEFS_VH

// register byte offsets
`define REG_CTRL      8'h00
`define REG_STATION   8'h04
`define REG_SPEED     8'h08
`define REG_PARAM     8'h0C
`define REG_TLIM      8'h10
`define REG_STATUS    8'h14
`define REG_IRQ_STAT  8'h18
`define REG_IRQ_MASK  8'h1C
`define REG_POSITION  8'h20
`define REG_INPOS_WIN 8'h24

// control register bits
`define CTRL_START    0
`define CTRL_MODE1    1
`define CTRL_MODE2    2
`define CTRL_TWO_STN  3
`define CTRL_DIRECT   4

// parameter register fields
`define PAR_OPSEL_LO  12
`define PAR_OPSEL_HI  15
`define PAR_JOG_BIT   0
`define PAR_DIR_BIT   4
`define PAR_DIV_LO    16
`define PAR_DIV_HI    23
`define OPSEL_INDEXER 4'h1

// status and interrupt bits
`define ST_DONE       0
`define ST_INPOS      1
`define ST_WARN       2
`define ST_TLIM2      3
`define ST_MOVING     4
`define IRQ_WARN      0
`define IRQ_DONE      1
`define IRQ_INPOS     2
`define IRQ_BITS      3

// reset values and station pitch shift
`define PARAM_RST     32'h0004_1000
`define TLIM_RST      32'h0000_0064
`define WIN_RST       32'h0000_0010
`define PITCH_SHIFT   8

// bus transfer size and the jog speed taken from table entry 1
`define XFER_WORD       3'h2
`define JOG_TABLE_SPEED 16'h0001

`endif

// *** design/delay_timer.v ***
// programmable one-shot delay counted in slow ticks
`timescale 1ns/1ps
module delay_timer #(
   parameter W = 16
) (
   input  wire         hclk,
   input  wire         hresetn,
   input  wire         tick,
   input  wire         arm,
   input  wire [W-1:0] length,
   output reg          expired_q
);
   reg [W-1:0] cnt_q;
   // counts while armed; disarm clears at once
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q     <= {W{1'b0}};
         expired_q <= 1'b0;
      end else if (!arm) begin
         cnt_q     <= {W{1'b0}};
         expired_q <= 1'b0;
      end else if (!expired_q) begin
         if (cnt_q >= length)
            expired_q <= 1'b1;
         else if (tick)
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// *** design/indexer_ctrl.v ***
// station positioning and jog sequencer with ahb-lite register slave
`timescale 1ns/1ps
`include "indexer_defs.vh"
module indexer_ctrl #(
   parameter TICK_DIV = 50000,
   parameter POS_W    = 16
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         irq_q,
   output reg         movement_done_flag,
   output reg         in_position_flag,
   output reg         next_station_warning,
   output reg         torque_limit2_active,
   output reg  [15:0] torque_limit_out
);
   localparam S_IDLE = 2'd0;
   localparam S_POS  = 2'd1;
   localparam S_JOG  = 2'd2;
   localparam S_STOP = 2'd3;

   reg [31:0]      ctrl_q, station_q, speed_q, param_q, tlim_q, win_q;
   reg [`IRQ_BITS-1:0] irq_stat_q, irq_mask_q;
   reg [1:0]       state_q;
   reg [POS_W-1:0] pos_q, target_q;
   reg [15:0]      run_speed_q;
   reg             start_prev_q, dir_q, power_chk_q;
   reg [15:0]      tick_cnt_q;
   reg             tick_q;
   reg             wr_pend_q;
   reg [7:0]       addr_q;

   // station spacing: one station each pitch of position counts
   function [POS_W-1:0] station_pos;
      input [7:0] n;
      begin
         station_pos = {{(POS_W-8){1'b0}}, n} << `PITCH_SHIFT;
      end
   endfunction
   // offset within current pitch, used twice for window checks
   function in_window;
      input [POS_W-1:0] p;
      input [15:0]      w;
      reg   [POS_W-1:0] one;
      reg   [POS_W-1:0] pitch;
      reg   [POS_W-1:0] off;
      begin
         one       = {{(POS_W-1){1'b0}}, 1'b1};
         pitch     = one << `PITCH_SHIFT;
         off       = p & (pitch - one);
         // distance to the station behind and to the one ahead
         in_window = (off <= w) || ((pitch - off) <= w);
      end
   endfunction

   wire [7:0] divisions  = param_q[`PAR_DIV_HI:`PAR_DIV_LO];
   wire       indexer_en = (param_q[`PAR_OPSEL_HI:`PAR_OPSEL_LO] == `OPSEL_INDEXER);
   wire       mode_man   = ctrl_q[`CTRL_MODE1] & ~ctrl_q[`CTRL_MODE2];
   wire       mode_auto2 = ctrl_q[`CTRL_MODE1] & ctrl_q[`CTRL_MODE2];
   wire       start      = ctrl_q[`CTRL_START];
   wire       start_rise = start & ~start_prev_q;
   wire       plain_jog  = param_q[`PAR_JOG_BIT];
   wire       stn_bad    = (station_q[7:0] > divisions - 8'h01);
   wire       at_station = in_window(pos_q, win_q[15:0]);
   // direct speed only when two stations occupied, else table entry number
   wire       direct_ok  = ctrl_q[`CTRL_DIRECT] & ctrl_q[`CTRL_TWO_STN];
   wire [15:0] pick_speed = direct_ok ? speed_q[15:0] : {13'h0000, speed_q[2:0]};
   wire       tlim_arm;
   wire       ev_done, ev_inpos, ev_warn;
   // narrow transfers are not decoded, so a byte write cannot half-load a word
   wire       word_xfer  = (hsize == `XFER_WORD);

   // slow tick divider for the torque limit delay
   // counter is 16 bits wide, so the divide ratio must fit in 16 bits
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_DIV[15:0] - 16'h0001) begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   // ahb-lite slave: zero wait, writes land in data phase
   // every register answers in one cycle, so ready and response never move
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (hready) begin
         wr_pend_q <= hsel & htrans[1] & hwrite & word_xfer;
         addr_q    <= haddr;
      end
   end

   // read mux; unmapped addresses read zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite && word_xfer) begin
         if (haddr == `REG_CTRL)          hrdata <= ctrl_q;
         else if (haddr == `REG_STATION)  hrdata <= station_q;
         else if (haddr == `REG_SPEED)    hrdata <= speed_q;
         else if (haddr == `REG_PARAM)    hrdata <= param_q;
         else if (haddr == `REG_TLIM)     hrdata <= tlim_q;
         else if (haddr == `REG_STATUS)
            // upper half shows the speed latched by the last accepted start
            hrdata <= {run_speed_q, 11'h000, state_q != S_IDLE, torque_limit2_active,
                       next_station_warning, in_position_flag, movement_done_flag};
         else if (haddr == `REG_IRQ_STAT) hrdata <= {29'h0, irq_stat_q};
         else if (haddr == `REG_IRQ_MASK) hrdata <= {29'h0, irq_mask_q};
         else if (haddr == `REG_POSITION) hrdata <= {{(32-POS_W){1'b0}}, pos_q};
         else if (haddr == `REG_INPOS_WIN) hrdata <= win_q;
         else                             hrdata <= 32'h0000_0000;
      end
   end

   // write-one-to-clear strobe for the interrupt status
   wire wr_irq_clr = wr_pend_q && (addr_q == `REG_IRQ_STAT);

   // software-written registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q     <= 32'h0000_0000;
         station_q  <= 32'h0000_0000;
         speed_q    <= 32'h0000_0001;
         param_q    <= `PARAM_RST;
         tlim_q     <= `TLIM_RST;
         win_q      <= `WIN_RST;
         irq_mask_q <= {`IRQ_BITS{1'b0}};
      end else if (wr_pend_q) begin
         if (addr_q == `REG_CTRL)           ctrl_q     <= hwdata;
         else if (addr_q == `REG_STATION)   station_q  <= hwdata;
         else if (addr_q == `REG_SPEED)     speed_q    <= hwdata;
         else if (addr_q == `REG_PARAM)     param_q    <= hwdata;
         else if (addr_q == `REG_TLIM)      tlim_q     <= hwdata;
         else if (addr_q == `REG_INPOS_WIN) win_q      <= hwdata;
         else if (addr_q == `REG_IRQ_MASK)  irq_mask_q <= hwdata[`IRQ_BITS-1:0];
      end
   end

   // motion sequencer; start is edge-checked so a held start never relaunches
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q      <= S_IDLE;
         pos_q        <= {POS_W{1'b0}};
         target_q     <= {POS_W{1'b0}};
         run_speed_q  <= 16'h0000;
         dir_q        <= 1'b0;
         start_prev_q <= 1'b0;
         movement_done_flag   <= 1'b1;
         next_station_warning <= 1'b0;
      end else begin
         start_prev_q <= start;
         case (state_q)
            S_IDLE: begin
               if (start_rise && indexer_en && mode_auto2) begin
                  // auto mode 2 uses station word and speed word
                  if (stn_bad) begin
                     // start refused; warning stands until a valid auto mode 2 start
                     next_station_warning <= 1'b1;
                  end else begin
                     next_station_warning <= 1'b0;
                     target_q    <= station_pos(station_q[7:0]);
                     run_speed_q <= pick_speed;
                     dir_q       <= station_pos(station_q[7:0]) < pos_q;
                     movement_done_flag <= 1'b0;
                     state_q     <= S_POS;
                  end
               end else if (start_rise && indexer_en && mode_manual_ok(mode_man)) begin
                  // manual: station and speed selects ignored, entry 1 used
                  run_speed_q <= `JOG_TABLE_SPEED;
                  dir_q       <= param_q[`PAR_DIR_BIT];
                  movement_done_flag <= 1'b0;
                  state_q     <= S_JOG;
               end
            end
            S_POS: begin
               // one count per clock; the speed field is reported, not used for pacing
               if (pos_q == target_q) begin
                  movement_done_flag <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  pos_q <= dir_q ? pos_q - {{(POS_W-1){1'b0}}, 1'b1}
                                 : pos_q + {{(POS_W-1){1'b0}}, 1'b1};
               end
            end
            S_JOG: begin
               pos_q <= dir_q ? pos_q - {{(POS_W-1){1'b0}}, 1'b1}
                              : pos_q + {{(POS_W-1){1'b0}}, 1'b1};
               if (!start) begin
                  if (plain_jog) begin
                     movement_done_flag <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_STOP;
                  end
               end
            end
            S_STOP: begin
               // run on to the next station boundary reached after release
               if (pos_q[`PITCH_SHIFT-1:0] == {`PITCH_SHIFT{1'b0}}) begin
                  movement_done_flag <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  pos_q <= dir_q ? pos_q - {{(POS_W-1){1'b0}}, 1'b1}
                                 : pos_q + {{(POS_W-1){1'b0}}, 1'b1};
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   function mode_manual_ok;
      input m;
      begin
         mode_manual_ok = m;
      end
   endfunction

   // in-position: checked once after reset, then at each stop
   // the power-up test runs once so a later stop is never taken for it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_position_flag <= 1'b0;
         power_chk_q      <= 1'b0;
      end else begin
         power_chk_q <= 1'b1;
         if (!power_chk_q)
            in_position_flag <= at_station;
         else if (state_q != S_IDLE)
            in_position_flag <= 1'b0;
         else
            in_position_flag <= at_station & movement_done_flag;
      end
   end

   wire torque_limit2_active_w;
   assign tlim_arm = in_position_flag;
   delay_timer #(.W(16)) u_tlim_delay (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (tick_q),
      .arm       (tlim_arm),
      .length    (tlim_q[31:16]),
      .expired_q (torque_limit2_active_w)
   );

   // limit 2 only holds at rest; motion drops it at once rather than after the
   // timer and the in-position flag have both caught up
   wire limit2_sel = torque_limit2_active_w & tlim_arm & movement_done_flag;

   // torque limit selection after the programmed delay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         torque_limit2_active <= 1'b0;
         torque_limit_out     <= 16'hFFFF;
      end else begin
         torque_limit2_active <= limit2_sel;
         torque_limit_out     <= limit2_sel ? tlim_q[15:0] : 16'hFFFF;
      end
   end

   // interrupts: hardware set wins over write-one-to-clear
   // edge detectors reset to the flags' own reset levels, so no false event
   reg done_prev_q, inpos_prev_q, warn_prev_q;
   assign ev_done  = movement_done_flag & ~done_prev_q;
   assign ev_inpos = in_position_flag & ~inpos_prev_q;
   assign ev_warn  = next_station_warning & ~warn_prev_q;
   wire [`IRQ_BITS-1:0] ev_vec = {ev_inpos, ev_done, ev_warn};
   wire [`IRQ_BITS-1:0] clr_vec =
      wr_irq_clr ? hwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_prev_q  <= 1'b1;
         inpos_prev_q <= 1'b0;
         warn_prev_q  <= 1'b0;
         irq_stat_q   <= {`IRQ_BITS{1'b0}};
         irq_q        <= 1'b0;
      end else begin
         done_prev_q  <= movement_done_flag;
         inpos_prev_q <= in_position_flag;
         warn_prev_q  <= next_station_warning;
         irq_stat_q   <= (irq_stat_q & ~clr_vec) | ev_vec;
         irq_q        <= |(((irq_stat_q & ~clr_vec) | ev_vec) & irq_mask_q);
      end
   end
endmodule

// *** bench/indexer_ctrl_props.sv ***
// port assertions for the indexer sequencer
`timescale 1ns/1ps
module indexer_ctrl_props (
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp,
   input logic        irq_q,
   input logic        movement_done_flag,
   input logic        in_position_flag,
   input logic        next_station_warning,
   input logic        torque_limit2_active,
   input logic [15:0] torque_limit_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // read address phase taken by the slave
   wire rd_take = hsel && htrans[1] && !hwrite && hready;

   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_tlim_full: assert property (!torque_limit2_active |-> torque_limit_out == 16'hFFFF)
      else $error("torque limit not full while limit2 idle");
   a_tlim2_inpos: assert property ($rose(torque_limit2_active) |-> in_position_flag)
      else $error("limit2 selected outside position");
   a_inpos_first: assert property ($rose(in_position_flag) |-> !torque_limit2_active)
      else $error("limit2 active before delay");
   a_move_drops: assert property ($fell(movement_done_flag) |-> ##[0:2] !torque_limit2_active)
      else $error("limit2 kept during motion");
   // data only changes after a read has been taken
   a_rdata_hold: assert property (!$past(rd_take) && !$past(rd_take, 2) |-> $stable(hrdata))
      else $error("read data changed without a read");
   a_warn_release: assert property ($fell(next_station_warning) |-> ##[0:4] !movement_done_flag)
      else $error("warning cleared without a start");

   c_move: cover property ($fell(movement_done_flag));
   c_tlim2: cover property ($rose(torque_limit2_active));
   c_warn: cover property ($rose(next_station_warning));
   c_irq: cover property ($rose(irq_q));
endmodule

bind indexer_ctrl indexer_ctrl_props u_indexer_ctrl_props (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq_q, .movement_done_flag,
   .in_position_flag, .next_station_warning, .torque_limit2_active, .torque_limit_out);

// *** bench/host_master.sv ***
// ahb-lite master standing in for the host controller
`timescale 1ns/1ps
module host_master (
   input  logic        hclk,
   input  logic        hready,
   input  logic [31:0] hrdata,
   output logic        hsel,
   output logic [7:0]  haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata
);
   // bus idle at time zero
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // one single word transfer; no cycle count assumed, waits on hready
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

// *** bench/indexer_ctrl_tb_top.sv ***
// self-checking bench for the indexer sequencer
`timescale 1ns/1ps
`include "indexer_defs.vh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
`define WAITV(s, v, lim) for (int i = 0; i < lim && s !== v; i++) @(posedge hclk) #1;
module indexer_ctrl_tb_top;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq_q;
   logic        done;
   logic        inpos;
   logic        warn;
   logic        tl2;
   logic [15:0] torque;
   logic [31:0] q;
   int          fail_count = 0;
   int          n_tests = 0;

   // short tick keeps the torque delay brief
   indexer_ctrl #(.TICK_DIV(4)) u_indexer_ctrl (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq_q(irq_q), .movement_done_flag(done), .in_position_flag(inpos),
      .next_station_warning(warn), .torque_limit2_active(tl2), .torque_limit_out(torque));

   host_master u_host_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host_master.xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host_master.xfer(a, 1'b0, 32'h0, q);
   endtask
   // mode is written with start low first, so start sees a fresh rising edge
   task automatic go(input logic [31:0] m);
      wr(`REG_CTRL, m);
      wr(`REG_CTRL, m | 32'h1);
   endtask

   task automatic t_reset;
      `CHK("done", 1'b1, done)
      `CHK("torque", 16'hFFFF, torque)
      rd(`REG_PARAM);
      `CHK("param", `PARAM_RST, q)
      rd(`REG_TLIM);
      `CHK("tlim", `TLIM_RST, q)
      rd(8'h3C);
      `CHK("unmapped", 32'h0, q)
      `WAITV(inpos, 1'b1, 50)
      `CHK("inpos", 1'b1, inpos)
      $display("test reset ended");
   endtask

   task automatic t_auto;
      wr(`REG_TLIM, 32'h0002_0055);
      wr(`REG_STATION, 32'h1);
      wr(`REG_SPEED, 32'h1);
      go(32'h6);
      `WAITV(done, 1'b0, 10)
      `CHK("done_fall", 1'b0, done)
      wr(`REG_STATION, 32'h2);
      go(32'h6);
      `WAITV(done, 1'b1, 2000)
      rd(`REG_POSITION);
      `CHK("pos", 32'h100, q)
      `CHK("inpos", 1'b1, inpos)
      `WAITV(tl2, 1'b1, 100)
      `CHK("tl2_on", 1'b1, tl2)
      `CHK("tlim2", 16'h0055, torque)
      wr(`REG_CTRL, 32'h6);
      $display("test auto ended");
   endtask

   task automatic t_warn;
      wr(`REG_IRQ_MASK, 32'h1);
      wr(`REG_STATION, 32'h4);
      go(32'h6);
      `WAITV(irq_q, 1'b1, 20)
      `CHK("warn", 1'b1, warn)
      `CHK("irq", 1'b1, irq_q)
      wr(`REG_CTRL, 32'h6);
      wr(`REG_IRQ_STAT, 32'h1);
      `WAITV(irq_q, 1'b0, 5)
      `CHK("irq_clr", 1'b0, irq_q)
      wr(`REG_STATION, 32'h3);
      go(32'h6);
      `WAITV(done, 1'b0, 10)
      `WAITV(done, 1'b1, 2000)
      rd(`REG_POSITION);
      `CHK("pos3", 32'h300, q)
      `CHK("warn_off", 1'b0, warn)
      wr(`REG_CTRL, 32'h6);
      $display("test warning ended");
   endtask

   // wrong leading digit must keep the axis still
   task automatic t_opsel;
      wr(`REG_PARAM, 32'h0004_2000);
      wr(`REG_STATION, 32'h1);
      go(32'h6);
      repeat (20) @(posedge hclk);
      `CHK("idle", 1'b1, done)
      rd(`REG_POSITION);
      `CHK("pos_kept", 32'h300, q)
      wr(`REG_CTRL, 32'h6);
      wr(`REG_PARAM, `PARAM_RST);
      $display("test opsel ended");
   endtask

   // direct speed needs both enables, else the word is a table number
   task automatic t_speed;
      wr(`REG_SPEED, 32'h0000_0123);
      wr(`REG_STATION, 32'h2);
      go(32'h1E);
      `WAITV(done, 1'b0, 10)
      rd(`REG_STATUS);
      `CHK("moving", 1'b1, q[4])
      `CHK("direct", 16'h0123, q[31:16])
      `WAITV(done, 1'b1, 2000)
      wr(`REG_STATION, 32'h3);
      go(32'h16);
      `WAITV(done, 1'b0, 10)
      rd(`REG_STATUS);
      `CHK("table_no", 16'h0003, q[31:16])
      `WAITV(done, 1'b1, 2000)
      rd(`REG_POSITION);
      `CHK("pos_spd", 32'h300, q)
      wr(`REG_CTRL, 32'h6);
      $display("test speed ended");
   endtask

   // runs: indexer jog ccw, indexer jog cw, plain jog
   task automatic t_jog;
      shortint     d[2];
      logic [15:0] p0;
      for (int k = 0; k < 3; k++) begin
         wr(`REG_PARAM, `PARAM_RST | (k == 0 ? 32'h10 : 32'h0) | (k == 2 ? 32'h1 : 32'h0));
         rd(`REG_POSITION);
         p0 = q[15:0];
         wr(`REG_STATION, 32'h2);
         go(32'h2);
         `WAITV(done, 1'b0, 10)
         `CHK("jog_run", 1'b0, done)
         rd(`REG_STATUS);
         `CHK("jog_speed", 16'h0001, q[31:16])
         repeat (20) @(posedge hclk);
         wr(`REG_CTRL, 32'h2);
         `WAITV(done, 1'b1, 2000)
         `CHK("jog_stop", 1'b1, done)
         rd(`REG_POSITION);
         if (k < 2) begin
            `CHK("on_station", 8'h00, q[7:0])
            d[k] = q[15:0] - p0;
         end else begin
            `CHK("plain_off", 1'b1, q[7:0] != 8'h00)
         end
      end
      `CHK("direction", 1'b1, (d[0] > 0) != (d[1] > 0))
      $display("test jog ended");
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard, well beyond the expected run
   initial begin
      #600000;
      fail_count++;
      $display("mismatch watchdog expected end seen hang");
      conclude();
   end

   initial begin
      hresetn = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_auto();
      t_warn();
      t_opsel();
      t_speed();
      t_jog();
      conclude();
   end
endmodule
